// ===== flash_host_pkg.sv
`default_nettype none
package flash_host_pkg;

	// ==================================================================
	// Register port of the controller
	localparam int          REG_AW          = 8;
	localparam logic [7:0]  REG_CMD         = 8'h00;
	localparam logic [7:0]  REG_ADDR        = 8'h04;
	localparam logic [7:0]  REG_STATUS      = 8'h08;
	localparam logic [7:0]  REG_RESULT      = 8'h0C;
	localparam int          CMD_OP_LSB      = 0;
	localparam int          CMD_UNPROT_BIT  = 8;
	localparam int          ST_BUSY_BIT     = 0;
	localparam int          ST_DONE_BIT     = 1;
	localparam int          ST_FAIL_BIT     = 2;
	localparam int          ST_REFUSED_BIT  = 3;
	localparam int          ST_PROTDONE_BIT = 4;
	localparam logic [3:0]  CMD_RESET_VAL   = 4'h0;
	localparam logic [18:0] ADDR_RESET_VAL  = 19'h00000;
	localparam logic [7:0]  RESULT_RST_VAL  = 8'h00;

	// ==================================================================
	// Operations
	localparam logic [3:0] OP_RESET   = 4'h1;
	localparam logic [3:0] OP_READ    = 4'h2;
	localparam logic [3:0] OP_ID      = 4'h3;
	localparam logic [3:0] OP_VERIFY  = 4'h4;
	localparam logic [3:0] OP_CHIP_ER = 4'h5;
	localparam logic [3:0] OP_PROTECT = 4'h6;
	localparam logic [3:0] OP_HV_ID   = 4'h7;

	// ==================================================================
	// Flash command set
	localparam logic [18:0] UNLOCK_ADDR1  = 19'h00555;
	localparam logic [18:0] UNLOCK_ADDR2  = 19'h002AA;
	localparam logic [18:0] ANY_ADDR      = 19'h00000;
	localparam logic [7:0]  UNLOCK_DATA1  = 8'hAA;
	localparam logic [7:0]  UNLOCK_DATA2  = 8'h55;
	localparam logic [7:0]  CODE_RESET    = 8'hF0;
	localparam logic [7:0]  CODE_ID       = 8'h90;
	localparam logic [7:0]  CODE_ERASE_SU = 8'h80;
	localparam logic [7:0]  CODE_CHIP_ER  = 8'h10;
	localparam logic [7:0]  CODE_PROT_UL  = 8'h20;
	localparam logic [7:0]  CODE_DONTCARE = 8'h00;
	localparam logic [2:0]  LEN_RESET     = 3'h1;
	localparam logic [2:0]  LEN_ID        = 3'h3;
	localparam logic [2:0]  LEN_ERASE     = 3'h6;
	localparam logic [2:0]  LEN_PROTECT   = 3'h7;
	localparam int          SECTOR_MSB    = 18;
	localparam int          SECTOR_LSB    = 16;
	localparam int          ID_PIN_BIT    = 9;
	localparam int          PSEL_BIT      = 6;
	localparam int          A1_BIT        = 1;
	localparam int          POLL_BIT      = 7;
	localparam int          TOGGLE_BIT    = 6;
	localparam int          TLIMIT_BIT    = 5;

	// ==================================================================
	// Bus cycle timing
	localparam int         CLK_PERIOD_NS = 10;
	localparam int         T_WP_NS       = 40;
	localparam int         T_ACC_NS      = 70;
	localparam int         T_REC_NS      = 30;
	localparam logic [3:0] WP_CYC  = 4'((T_WP_NS + CLK_PERIOD_NS - 1)
		/ CLK_PERIOD_NS);
	localparam logic [3:0] ACC_CYC = 4'((T_ACC_NS + CLK_PERIOD_NS - 1)
		/ CLK_PERIOD_NS);
	localparam logic [3:0] REC_CYC = 4'((T_REC_NS + CLK_PERIOD_NS - 1)
		/ CLK_PERIOD_NS);

	typedef enum logic [1:0] {
		BC_IDLE   = 2'b00,
		BC_SETUP  = 2'b01,
		BC_STROBE = 2'b11,
		BC_HOLD   = 2'b10
	} bc_state_t;

	typedef enum logic [2:0] {
		M_IDLE   = 3'b000,
		M_NEXT   = 3'b001,
		M_WAIT_W = 3'b011,
		M_WAIT_R = 3'b010,
		M_POLL   = 3'b110,
		M_ABORT  = 3'b111
	} m_state_t;

endpackage : flash_host_pkg
`default_nettype wire

// ===== flash_bus_cycle.sv
`timescale 1ns/100ps
`default_nettype none
module flash_bus_cycle
	import flash_host_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic        start,
	input  wire logic        is_write,
	input  wire logic [18:0] addr,
	input  wire logic [7:0]  wdata,
	input  wire logic [7:0]  dq_in,
	output logic             ce_n,
	output logic             oe_n,
	output logic             we_n,
	output logic      [18:0] a,
	output logic      [7:0]  dq_out,
	output logic             dq_oe,
	output logic      [7:0]  rdata,
	output logic             done
);

	bc_state_t  state;
	logic       wr;
	logic [3:0] cnt;

	// ==================================================================
	// One strobe cycle: address and data stand from chip select low
	// until after the strobe has risen, so the far end latches stable
	// values on either edge.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state  <= BC_IDLE;
			ce_n   <= 1'b1;
			oe_n   <= 1'b1;
			we_n   <= 1'b1;
			a      <= ADDR_RESET_VAL;
			dq_out <= CODE_DONTCARE;
			dq_oe  <= 1'b0;
			rdata  <= RESULT_RST_VAL;
			done   <= 1'b0;
			wr     <= 1'b0;
			cnt    <= 4'h0;
		end else begin
			unique case (state)
				BC_IDLE: begin
					done <= 1'b0;
					if (start) begin
						a      <= addr;
						ce_n   <= 1'b0;
						dq_out <= wdata;
						dq_oe  <= is_write;
						wr     <= is_write;
						state  <= BC_SETUP;
					end
				end
				BC_SETUP: begin
					// Never both strobes low at once
					if (wr) begin
						we_n <= 1'b0;
						cnt  <= WP_CYC - 4'h1;
					end else begin
						oe_n <= 1'b0;
						cnt  <= ACC_CYC - 4'h1;
					end
					state <= BC_STROBE;
				end
				BC_STROBE: begin
					if (cnt == 4'h0) begin
						we_n  <= 1'b1;
						oe_n  <= 1'b1;
						if (!wr)
							rdata <= dq_in;
						cnt   <= REC_CYC - 4'h1;
						state <= BC_HOLD;
					end else begin
						cnt <= cnt - 4'h1;
					end
				end
				BC_HOLD: begin
					// Data still driven after the strobe rose
					if (cnt == 4'h0) begin
						ce_n  <= 1'b1;
						dq_oe <= 1'b0;
						done  <= 1'b1;
						state <= BC_IDLE;
					end else begin
						cnt <= cnt - 4'h1;
					end
				end
			endcase
		end
	end

endmodule : flash_bus_cycle
`default_nettype wire

// ===== flash_host_ctrl.sv
// Behaviour
// - Unlock writes use 555h/2AAh low addresses
// - After failure write F0h, then new command
// - Chip erase is six write cycles
// - Protect unlock, then write with select line
// - Verify without high voltage only after protect
//
// The address map and the address-and-strobe port were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
module flash_host_ctrl
	import flash_host_pkg::*;
(
	input  wire logic              CLK_SYS,
	input  wire logic              RST_N,
	input  wire logic [REG_AW-1:0] REG_ADDR_IN,
	input  wire logic [31:0]       REG_WDATA,
	input  wire logic              REG_WR,
	input  wire logic              REG_RD,
	output logic      [31:0]       REG_RDATA,
	output logic                   FLASH_CE_N,
	output logic                   FLASH_OE_N,
	output logic                   FLASH_WE_N,
	output logic      [18:0]       FLASH_A,
	input  wire logic [7:0]        FLASH_DQ_IN,
	output logic      [7:0]        FLASH_DQ_OUT,
	output logic                   FLASH_DQ_OE,
	output logic                   FLASH_ID_HV_EN
);

	m_state_t    mstate;
	logic [3:0]  op;
	logic        unprot;
	logic [18:0] target;
	logic        busy;
	logic        done_flag;
	logic        fail_flag;
	logic        refused;
	logic        prot_done;
	logic [7:0]  result;
	logic [2:0]  step;
	logic        poll_first;
	logic        prev_toggle;
	logic        prev_tlimit;
	logic        bc_start;
	logic        bc_write;
	logic [18:0] bc_addr;
	logic [7:0]  bc_wdata;
	logic [7:0]  bc_rdata;
	logic        bc_done;
	logic        cmd_wr;
	logic [3:0]  wop;
	logic        op_ok;

	// ==================================================================
	// Command sequence tables
	function automatic logic [2:0] seq_len(input logic [3:0] o);
		unique case (o)
			OP_RESET:   seq_len = LEN_RESET;
			OP_ID:      seq_len = LEN_ID;
			OP_CHIP_ER: seq_len = LEN_ERASE;
			OP_PROTECT: seq_len = LEN_PROTECT;
			default:    seq_len = 3'h0;
		endcase
	endfunction : seq_len

	// Returns {address, data} of one write; upper lines stay low except the sector lines of the protect select write
	function automatic logic [26:0] seq_step(input logic [3:0] o,
		input logic [2:0] i, input logic [18:0] t, input logic u);
		logic [18:0] lock_addr;
		lock_addr = ANY_ADDR;
		lock_addr[SECTOR_MSB:SECTOR_LSB] = t[SECTOR_MSB:SECTOR_LSB];
		lock_addr[ID_PIN_BIT] = 1'b1;
		lock_addr[PSEL_BIT] = u;
		if (o == OP_RESET)
			seq_step = {ANY_ADDR, CODE_RESET};
		else if (i == 3'h6)
			seq_step = {lock_addr, CODE_DONTCARE};
		else if (i == 3'h0 || i == 3'h3)
			seq_step = {UNLOCK_ADDR1, UNLOCK_DATA1};
		else if (i == 3'h1 || i == 3'h4)
			seq_step = {UNLOCK_ADDR2, UNLOCK_DATA2};
		else if (o == OP_ID)
			seq_step = {UNLOCK_ADDR1, CODE_ID};
		else if (i == 3'h2)
			seq_step = {UNLOCK_ADDR1, CODE_ERASE_SU};
		else if (o == OP_CHIP_ER)
			seq_step = {UNLOCK_ADDR1, CODE_CHIP_ER};
		else
			seq_step = {UNLOCK_ADDR1, CODE_PROT_UL};
	endfunction : seq_step

	function automatic logic [18:0] read_addr(input logic [3:0] o,
		input logic [18:0] t);
		logic [18:0] rd_addr;
		rd_addr = ANY_ADDR;
		unique case (o)
			OP_ID:  rd_addr[0] = t[0];
			OP_HV_ID: begin
				rd_addr[0] = t[0];
				rd_addr[ID_PIN_BIT] = 1'b1;
			end
			OP_VERIFY: begin
				rd_addr[SECTOR_MSB:SECTOR_LSB] =
					t[SECTOR_MSB:SECTOR_LSB];
				rd_addr[ID_PIN_BIT] = 1'b1;
				rd_addr[A1_BIT] = 1'b1;
			end
			default: rd_addr = t;
		endcase
		read_addr = rd_addr;
	endfunction : read_addr

	assign cmd_wr = REG_WR && (REG_ADDR_IN == REG_CMD);
	assign wop    = REG_WDATA[CMD_OP_LSB +: 4];
	// Only documented sequences go out; a verify without high voltage is
	// refused unless the last operation was a protect write
	assign op_ok  = (wop >= OP_RESET) && (wop <= OP_HV_ID)
		&& (wop != OP_VERIFY || prot_done);

	// ==================================================================
	// Target address register
	always_ff @(posedge CLK_SYS or negedge RST_N) begin
		if (!RST_N)
			target <= ADDR_RESET_VAL;
		else if (REG_WR && REG_ADDR_IN == REG_ADDR && !busy)
			target <= REG_WDATA[18:0];
	end

	// ==================================================================
	// Operation sequencer; commands written before the flash finishes are ignored
	always_ff @(posedge CLK_SYS or negedge RST_N) begin
		if (!RST_N) begin
			mstate      <= M_IDLE;
			op          <= CMD_RESET_VAL;
			unprot      <= 1'b0;
			busy        <= 1'b0;
			done_flag   <= 1'b0;
			fail_flag   <= 1'b0;
			refused     <= 1'b0;
			prot_done   <= 1'b0;
			result      <= RESULT_RST_VAL;
			step        <= 3'h0;
			poll_first  <= 1'b1;
			prev_toggle <= 1'b0;
			prev_tlimit <= 1'b0;
			bc_start    <= 1'b0;
			bc_write    <= 1'b0;
			bc_addr     <= ADDR_RESET_VAL;
			bc_wdata    <= CODE_DONTCARE;
			FLASH_ID_HV_EN <= 1'b0;
		end else begin
			bc_start <= 1'b0;
			unique case (mstate)
				M_IDLE: begin
					if (cmd_wr) begin
						refused <= !op_ok;
						if (op_ok) begin
							op         <= wop;
							unprot     <= REG_WDATA[CMD_UNPROT_BIT];
							busy       <= 1'b1;
							done_flag  <= 1'b0;
							fail_flag  <= 1'b0;
							step       <= 3'h0;
							poll_first <= 1'b1;
							FLASH_ID_HV_EN <= (wop == OP_HV_ID);
							mstate     <= M_NEXT;
						end
					end
				end
				M_NEXT: begin
					bc_start <= 1'b1;
					if (step < seq_len(op)) begin
						bc_write <= 1'b1;
						{bc_addr, bc_wdata} <= seq_step(op, step, target, unprot);
						mstate <= M_WAIT_W;
					end else begin
						bc_write <= 1'b0;
						bc_addr  <= read_addr(op, target);
						// Polling starts once the last strobe has risen
						mstate   <= (op == OP_CHIP_ER) ? M_POLL : M_WAIT_R;
					end
				end
				M_WAIT_W: begin
					if (bc_done) begin
						step   <= step + 3'h1;
						mstate <= M_NEXT;
					end
				end
				M_WAIT_R: begin
					if (bc_done) begin
						result <= bc_rdata;
						busy   <= 1'b0;
						done_flag <= 1'b1;
						prot_done <= (op == OP_PROTECT);
						FLASH_ID_HV_EN <= 1'b0;
						mstate <= M_IDLE;
						if (op == OP_RESET || op == OP_PROTECT)
							result <= RESULT_RST_VAL;
					end
				end
				M_POLL: begin
					if (bc_done) begin
						prev_toggle <= bc_rdata[TOGGLE_BIT];
						prev_tlimit <= bc_rdata[TLIMIT_BIT];
						poll_first  <= 1'b0;
						result      <= bc_rdata;
						if (!poll_first && bc_rdata[POLL_BIT]
							&& bc_rdata[TOGGLE_BIT] == prev_toggle) begin
							busy      <= 1'b0;
							done_flag <= 1'b1;
							prot_done <= 1'b0;
							mstate    <= M_IDLE;
						end else if (!poll_first && bc_rdata[TLIMIT_BIT]
							&& prev_tlimit
							&& bc_rdata[TOGGLE_BIT] != prev_toggle) begin
							// Limit flag on two reads in a row: array data
							// read right after a good finish may carry it
							// Failed flash stays busy until told to abort
							bc_start <= 1'b1;
							bc_write <= 1'b1;
							{bc_addr, bc_wdata} <= {ANY_ADDR, CODE_RESET};
							mstate   <= M_ABORT;
						end else begin
							bc_start <= 1'b1;
						end
					end
				end
				M_ABORT: begin
					if (bc_done) begin
						busy      <= 1'b0;
						fail_flag <= 1'b1;
						prot_done <= 1'b0;
						mstate    <= M_IDLE;
					end
				end
			endcase
		end
	end

	// ==================================================================
	// Register read port, data valid only the cycle after the strobe
	always_ff @(posedge CLK_SYS or negedge RST_N) begin
		if (!RST_N) begin
			REG_RDATA <= 32'h00000000;
		end else begin
			REG_RDATA <= 32'h00000000;
			if (REG_RD) begin
				unique case (REG_ADDR_IN)
					REG_CMD:    REG_RDATA <= {23'h0, unprot, 4'h0, op};
					REG_ADDR:   REG_RDATA <= {13'h0, target};
					REG_STATUS: REG_RDATA <= {27'h0, prot_done, refused,
						fail_flag, done_flag, busy};
					REG_RESULT: REG_RDATA <= {24'h0, result};
					default:    REG_RDATA <= 32'h00000000;
				endcase
			end
		end
	end

	flash_bus_cycle u_cycle (
		.clk      (CLK_SYS),
		.rst_n    (RST_N),
		.start    (bc_start),
		.is_write (bc_write),
		.addr     (bc_addr),
		.wdata    (bc_wdata),
		.dq_in    (FLASH_DQ_IN),
		.ce_n     (FLASH_CE_N),
		.oe_n     (FLASH_OE_N),
		.we_n     (FLASH_WE_N),
		.a        (FLASH_A),
		.dq_out   (FLASH_DQ_OUT),
		.dq_oe    (FLASH_DQ_OE),
		.rdata    (bc_rdata),
		.done     (bc_done)
	);

endmodule : flash_host_ctrl
`default_nettype wire

// ===== flash_host_ctrl_asserts.sv
`timescale 1ns/100ps
`default_nettype none
module flash_host_ctrl_asserts (
	input wire logic        CLK_SYS,
	input wire logic        RST_N,
	input wire logic        REG_RD,
	input wire logic [31:0] REG_RDATA,
	input wire logic        FLASH_CE_N,
	input wire logic        FLASH_OE_N,
	input wire logic        FLASH_WE_N,
	input wire logic [18:0] FLASH_A,
	input wire logic [7:0]  FLASH_DQ_OUT,
	input wire logic        FLASH_DQ_OE,
	input wire logic        FLASH_ID_HV_EN
);
	// ==========
	// Flash pins
	default clocking cb @(posedge CLK_SYS); endclocking
	default disable iff (!RST_N);
	AST_NO_WE_OE: assert property (FLASH_WE_N || FLASH_OE_N)
		else $error("both strobes low");
	AST_WE_PULSE: assert property ($fell(FLASH_WE_N) |->
		(!FLASH_WE_N && !FLASH_CE_N)[*4] ##1 FLASH_WE_N)
		else $error("bad write pulse");
	AST_OE_PULSE: assert property ($fell(FLASH_OE_N) |->
		!FLASH_OE_N[*7] ##1 FLASH_OE_N)
		else $error("bad read pulse");
	AST_WR_DRIVE: assert property (!FLASH_WE_N |-> FLASH_DQ_OE)
		else $error("write not driven");
	AST_RD_FLOAT: assert property (!FLASH_OE_N |-> !FLASH_DQ_OE)
		else $error("read while driving");
	AST_A_STABLE: assert property (!FLASH_CE_N && !$past(FLASH_CE_N)
		|-> $stable(FLASH_A) && $stable(FLASH_DQ_OUT))
		else $error("address moved");
	AST_UNLOCK: assert property (!FLASH_WE_N && FLASH_DQ_OUT == 8'hAA
		|-> FLASH_A[10:0] == 11'h555)
		else $error("bad unlock address");
	AST_HV_READ: assert property (!FLASH_OE_N && FLASH_ID_HV_EN
		|-> FLASH_A[9] && !FLASH_A[1])
		else $error("hv read broken");
	AST_HV_NO_WR: assert property (FLASH_ID_HV_EN |-> FLASH_WE_N)
		else $error("write under high voltage");
	cover property ($fell(FLASH_WE_N));
	cover property ($fell(FLASH_OE_N) && FLASH_A[9]);
	cover property (REG_RD ##1 REG_RDATA[2]);
endmodule : flash_host_ctrl_asserts
bind flash_host_ctrl flash_host_ctrl_asserts i_chk (.CLK_SYS(CLK_SYS),
	.RST_N(RST_N), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA),
	.FLASH_CE_N(FLASH_CE_N), .FLASH_OE_N(FLASH_OE_N),
	.FLASH_WE_N(FLASH_WE_N), .FLASH_A(FLASH_A),
	.FLASH_DQ_OUT(FLASH_DQ_OUT), .FLASH_DQ_OE(FLASH_DQ_OE),
	.FLASH_ID_HV_EN(FLASH_ID_HV_EN));
`default_nettype wire

// ===== flash_dev_model.sv
`timescale 1ns/100ps
`default_nettype none
module flash_dev_model #(
	parameter logic [7:0] MFR   = 8'h3E, // Arbitrary value
	parameter logic [7:0] DEV   = 8'h71, // Arbitrary value
	parameter int         POLLS = 5
) (
	input wire logic        ce_n,
	input wire logic        oe_n,
	input wire logic        we_n,
	input wire logic [18:0] a,
	input wire logic [7:0]  d,
	input wire logic        hv,
	input wire logic        fail,
	output logic      [7:0] q
);
	// ==========
	// Command decoder
	logic [2:0]  step = 3'h0;
	logic [2:0]  mode = 3'h0;
	logic [7:0]  prot = 8'h00;
	logic [18:0] la   = 19'h00000;
	logic        tog  = 1'b0;
	logic        ers  = 1'b0;
	int          np   = 0;
	logic        ok;
	logic [7:0]  rd;
	logic        w_on;
	logic        r_on;
	logic        p_wr = 1'b0;
	logic        p_rd = 1'b0;
	// One process owns all decoder state; strobe edges come from history
	always @(we_n or ce_n or oe_n) begin
		w_on = !we_n && !ce_n;
		r_on = !oe_n && !ce_n;
		// Address on the later falling strobe, data on the earlier rising
		if (w_on && !p_wr)
			la = a;
		if (!w_on && p_wr) begin
			if (mode == 3'h2) begin
				if (d == 8'hF0 && fail) mode = 3'h0;
			end else if (d == 8'hF0) begin
				step = 3'h0;
				mode = 3'h0;
			end else if (mode == 3'h3 && la[9]) begin
				if (la[6]) prot = 8'h00;
				else prot[la[18:16]] = 1'b1;
				mode = 3'h4;
			end else begin
				// Upper lines never looked at here
				if (step == 3'h0 || step == 3'h3)
					ok = la[10:0] == 11'h555 && d == 8'hAA;
				else if (step == 3'h1 || step == 3'h4)
					ok = la[10:0] == 11'h2AA && d == 8'h55;
				else if (step == 3'h2)
					ok = la[10:0] == 11'h555
						&& (d == 8'h90 || d == 8'h80);
				else
					ok = la[10:0] == 11'h555
						&& (d == 8'h10 || d == 8'h20);
				if (!ok) begin
					step = 3'h0;
					mode = 3'h0;
				end else if (step == 3'h2 && d == 8'h90) begin
					step = 3'h0;
					mode = 3'h1;
				end else if (step == 3'h5) begin
					step = 3'h0;
					mode = (d == 8'h10) ? 3'h2 : 3'h3;
					np = 0;
				end else
					step = step + 3'h1;
			end
		end
		// Pre-program and erase are one busy span seen only through status
		if (!r_on && p_rd && mode == 3'h2) begin
			tog = ~tog;
			np = np + 1;
			if (np == POLLS && !fail) begin
				mode = 3'h0;
				ers = 1'b1;
			end
		end
		p_wr = w_on;
		p_rd = r_on;
	end
	always_comb begin
		if (hv && a[9] && !a[1]) rd = a[0] ? DEV : MFR;
		else if (mode == 3'h1 && !a[1]) rd = a[0] ? DEV : MFR;
		else if (mode == 3'h4 && a[1]) rd = {7'h00, prot[a[18:16]]};
		else if (mode == 3'h2) rd = {1'b0, tog, fail, 5'h00};
		else rd = ers ? 8'hFF : a[7:0] ^ 8'h3C;
	end
	// Released lines show garbage, never the last value
	assign q = (!ce_n && !oe_n) ? rd : ~rd;
endmodule : flash_dev_model
`default_nettype wire

// ===== tb.sv
`timescale 1ns/100ps
`default_nettype none
module tb import flash_host_pkg::*;;
	localparam logic [7:0] MFR = 8'h3E; // Arbitrary value
	localparam logic [7:0] DEV = 8'h71; // Arbitrary value
	logic        clk = 1'b0;
	logic        rst_n = 1'b0;
	logic [7:0]  r_ad = 8'h00;
	logic [31:0] r_wd = 32'h0;
	logic        r_wr = 1'b0;
	logic        r_rd = 1'b0;
	logic        rd_q = 1'b0;
	logic        fail = 1'b0;
	logic [31:0] r_q, e_v, e_m, last, ad;
	logic [31:0] seed = 32'h0000C0CF;
	logic        ce_n, oe_n, we_n, dq_oe, hv;
	logic [18:0] fa;
	logic [7:0]  dq_i, dq_o;
	logic [31:0] ev[$];
	logic [31:0] em[$];
	int          n_fail = 0;
	int          cmp_count = 0;
	flash_host_ctrl i_flash_host_ctrl (.CLK_SYS(clk), .RST_N(rst_n),
		.REG_ADDR_IN(r_ad), .REG_WDATA(r_wd), .REG_WR(r_wr),
		.REG_RD(r_rd), .REG_RDATA(r_q), .FLASH_CE_N(ce_n),
		.FLASH_OE_N(oe_n), .FLASH_WE_N(we_n), .FLASH_A(fa),
		.FLASH_DQ_IN(dq_i), .FLASH_DQ_OUT(dq_o), .FLASH_DQ_OE(dq_oe),
		.FLASH_ID_HV_EN(hv));
	flash_dev_model #(.MFR(MFR), .DEV(DEV)) i_flash_dev_model (
		.ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .a(fa), .d(dq_o),
		.hv(hv), .fail(fail), .q(dq_i));
	// ==========
	// Bus tasks and result watcher
	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : xs
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		r_ad <= a;
		r_wd <= v;
		r_wr <= 1'b1;
		@(posedge clk);
		r_wr <= 1'b0;
		@(posedge clk);
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] v, m);
		ev.push_back(v);
		em.push_back(m);
		r_ad <= a;
		r_rd <= 1'b1;
		@(posedge clk);
		r_rd <= 1'b0;
		@(posedge clk);
	endtask : rd
	task automatic run(input logic [8:0] c, input logic [18:0] a);
		wr(REG_ADDR, {13'h0, a});
		wr(REG_CMD, {23'h0, c});
		repeat (2) @(posedge clk);
		for (int k = 0; k < 400; k++) begin
			rd(REG_STATUS, 32'h0, 32'h0);
			@(posedge clk);
			if (last[ST_BUSY_BIT] === 1'b0) break;
		end
		// A flash that never finishes must not pass silently
		if (last[ST_BUSY_BIT] !== 1'b0) begin
			n_fail++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, last, 32'h0);
		end
	endtask : run
	task automatic conclude();
		$display("compares %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : conclude
	always @(posedge clk) begin
		if (rd_q) begin
			e_v = ev.pop_front();
			e_m = em.pop_front();
			last = r_q;
			if (e_m != 32'h0) begin
				cmp_count++;
				if ((r_q & e_m) !== (e_v & e_m)) begin
					n_fail++;
					$display("MISMATCH t=%0t got=%h exp=%h", $time, r_q, e_v);
				end
			end
		end
		rd_q <= r_rd;
	end
	initial forever #5 clk = ~clk;
	initial begin
		// Tests need about 1.2k cycles; the limit is 30k cycles, about 25 times that
		#300000;
		n_fail++;
		conclude();
	end
	// ==========
	// Scenarios
	initial begin
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		rd(REG_STATUS, 32'h0, 32'hFFFFFFFF);
		rd(REG_RESULT, 32'h0, 32'hFFFFFFFF);
		rd(8'h10, 32'h0, 32'hFFFFFFFF);
		$display("test done: reset values");
		run({5'h0, OP_RESET}, 19'h0);
		rd(REG_STATUS, 32'h2, 32'h1F);
		for (int i = 0; i < 8; i++) begin
			ad = xs();
			ad[0] = i[0];
			if (i < 4) begin
				run({5'h0, OP_READ}, ad[18:0]);
				rd(REG_RESULT, {24'h0, ad[7:0] ^ 8'h3C}, 32'hFF);
			end else begin
				run({5'h0, i < 6 ? OP_ID : OP_HV_ID}, ad[18:0]);
				rd(REG_RESULT, {24'h0, ad[0] ? DEV : MFR}, 32'hFF);
				run({5'h0, OP_RESET}, 19'h0);
			end
		end
		$display("test done: read and identifier");
		run({5'h0, OP_VERIFY}, 19'h30000);
		rd(REG_STATUS, 32'h8, 32'h8);
		run({5'h0, 4'h8}, 19'h0);
		rd(REG_STATUS, 32'h8, 32'h9);
		rd(REG_CMD, {28'h0, OP_RESET}, 32'h1FF);
		for (int i = 0; i < 3; i++) begin
			run({i == 2, 4'h0, OP_PROTECT}, 19'h30000);
			rd(REG_STATUS, 32'h12, 32'h1F);
			run({5'h0, OP_VERIFY}, i == 1 ? 19'h50000 : 19'h30000);
			rd(REG_RESULT, {31'h0, i == 0}, 32'hFF);
		end
		rd(REG_ADDR, 32'h30000, 32'h7FFFF);
		$display("test done: protect");
		run({5'h0, OP_CHIP_ER}, 19'h0);
		rd(REG_STATUS, 32'h2, 32'h7);
		rd(REG_RESULT, 32'hFF, 32'hFF);
		fail <= 1'b1;
		run({5'h0, OP_CHIP_ER}, 19'h0);
		rd(REG_STATUS, 32'h4, 32'h7);
		rd(REG_RESULT, 32'h20, 32'h20);
		fail <= 1'b0;
		run({5'h0, OP_RESET}, 19'h0);
		run({5'h0, OP_READ}, 19'h12345);
		rd(REG_RESULT, 32'hFF, 32'hFF);
		$display("test done: chip erase");
		conclude();
	end
endmodule : tb
`default_nettype wire
